// ### hdl/icm_host_end.sv
// host end: drives clock and sequences writes and dummy-write reads
`timescale 1ns/1ns
`default_nettype none
`include "icm_defs.svh"
module icm_host_end #(
    parameter int QTR = `ICM_QTR_CYC,
    parameter int DEPTH = `ICM_FIFO_DEPTH
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    icm_link_if.host link,
    input wire logic cmd_valid_i,
    input wire logic cmd_read_i,
    input wire logic [6:0] cmd_addr_i,
    input wire logic [7:0] cmd_ptr_i,
    input wire logic [4:0] cmd_len_i,
    output logic cmd_ready_o,
    input wire logic wdata_valid_i,
    input wire logic [7:0] wdata_i,
    output logic wdata_ready_o,
    output logic rdata_valid_o,
    output logic [7:0] rdata_o,
    input wire logic rdata_ready_i,
    output logic busy_o,
    output logic nack_o
);
    icm_pkg::icm_host_state_type state_q;
    icm_pkg::icm_host_step_type step_q;
    logic [15:0] qcnt_q;
    logic tick, ack, fifo_rdy, push_q, drv_lo_q;
    logic [1:0] qph_q;
    logic [8:0] tx_q, rx_q;
    logic [3:0] bit_q;
    logic [4:0] len_q;
    logic [6:0] addr_q;
    logic [7:0] ptr_q;
    logic rd_q, scl_oen_q, sda_oen_q, cmd_ready_q, wready_q, busy_q, nack_q;

    // ------------------------------------------------------------
    // quarter-bit divider
    // ------------------------------------------------------------
    assign tick = (qcnt_q == 16'(QTR - 1));
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            qcnt_q <= 16'h0000;
        end else begin
            qcnt_q <= tick ? 16'h0000 : qcnt_q + 16'h0001;
        end
    end

    assign ack = ~rx_q[0];
    assign link.scl_o = drv_lo_q;
    assign link.h_sda_o = drv_lo_q;
    assign link.scl_oe_n = scl_oen_q;
    assign link.h_sda_oe_n = sda_oen_q;
    assign cmd_ready_o = cmd_ready_q;
    assign wdata_ready_o = wready_q;
    assign busy_o = busy_q;
    assign nack_o = nack_q;

    // ------------------------------------------------------------
    // transfer sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= icm_pkg::hs_idle;
            step_q <= icm_pkg::st_addr_w;
            qph_q <= 2'h0;
            tx_q <= 9'h1FF;
            rx_q <= 9'h000;
            bit_q <= 4'h0;
            len_q <= 5'h00;
            addr_q <= 7'h00;
            ptr_q <= 8'h00;
            rd_q <= 1'b0;
            scl_oen_q <= 1'b1;
            sda_oen_q <= 1'b1;
            cmd_ready_q <= 1'b0;
            wready_q <= 1'b0;
            busy_q <= 1'b0;
            nack_q <= 1'b0;
            push_q <= 1'b0;
            drv_lo_q <= 1'b0;
        end else begin
            push_q <= 1'b0;
            case (state_q)
                icm_pkg::hs_idle: begin
                    cmd_ready_q <= 1'b1;
                    if (cmd_valid_i && cmd_ready_q) begin
                        cmd_ready_q <= 1'b0;
                        busy_q <= 1'b1;
                        nack_q <= 1'b0;
                        rd_q <= cmd_read_i;
                        addr_q <= cmd_addr_i;
                        ptr_q <= cmd_ptr_i;
                        len_q <= cmd_len_i;
                        step_q <= icm_pkg::st_addr_w;
                        qph_q <= 2'h0;
                        state_q <= icm_pkg::hs_start;
                    end
                end
                icm_pkg::hs_start: if (tick) begin
                    // release, clock high, data falls, clock low
                    qph_q <= qph_q + 2'h1;
                    case (qph_q)
                        2'h0: sda_oen_q <= 1'b1;
                        2'h1: scl_oen_q <= 1'b1;
                        2'h2: sda_oen_q <= 1'b0;
                        default: begin
                            scl_oen_q <= 1'b0;
                            state_q <= icm_pkg::hs_load;
                        end
                    endcase
                end
                icm_pkg::hs_load: begin
                    bit_q <= 4'h0;
                    qph_q <= 2'h0;
                    case (step_q)
                        icm_pkg::st_addr_w: begin
                            tx_q <= {addr_q, 2'h1};
                            state_q <= icm_pkg::hs_bits;
                        end
                        icm_pkg::st_ptr: begin
                            tx_q <= {ptr_q, 1'b1};
                            state_q <= icm_pkg::hs_bits;
                        end
                        icm_pkg::st_addr_r: begin
                            tx_q <= {addr_q, 2'h3};
                            state_q <= icm_pkg::hs_bits;
                        end
                        icm_pkg::st_wdat: begin
                            if (!wready_q) begin
                                wready_q <= 1'b1;
                            end else if (wdata_valid_i) begin
                                wready_q <= 1'b0;
                                tx_q <= {wdata_i, 1'b1};
                                state_q <= icm_pkg::hs_bits;
                            end
                        end
                        default: begin
                            // clock held low until the fifo has room;
                            // a push in flight is not yet in its flags
                            if (fifo_rdy && !push_q) begin
                                tx_q <= {8'hFF, len_q == 5'h01};
                                state_q <= icm_pkg::hs_bits;
                            end
                        end
                    endcase
                end
                icm_pkg::hs_bits: if (tick) begin
                    qph_q <= qph_q + 2'h1;
                    case (qph_q)
                        2'h0: sda_oen_q <= tx_q[8];
                        2'h1: scl_oen_q <= 1'b1;
                        2'h2: rx_q <= {rx_q[7:0], link.sda};
                        default: begin
                            scl_oen_q <= 1'b0;
                            tx_q <= {tx_q[7:0], 1'b1};
                            bit_q <= bit_q + 4'h1;
                            if (bit_q == 4'h8) begin
                                state_q <= icm_pkg::hs_load;
                                case (step_q)
                                    icm_pkg::st_addr_w: begin
                                        step_q <= icm_pkg::st_ptr;
                                    end
                                    icm_pkg::st_ptr: begin
                                        step_q <= rd_q ? icm_pkg::st_addr_r
                                                       : icm_pkg::st_wdat;
                                        if (rd_q) begin
                                            state_q <= icm_pkg::hs_start;
                                        end
                                    end
                                    icm_pkg::st_addr_r: begin
                                        step_q <= icm_pkg::st_rdat;
                                    end
                                    icm_pkg::st_rdat: push_q <= 1'b1;
                                    default: step_q <= step_q;
                                endcase
                                if (step_q == icm_pkg::st_wdat ||
                                    step_q == icm_pkg::st_rdat) begin
                                    len_q <= len_q - 5'h01;
                                    if (len_q <= 5'h01) begin
                                        state_q <= icm_pkg::hs_stop;
                                    end
                                end
                                if (!ack && step_q != icm_pkg::st_rdat) begin
                                    nack_q <= 1'b1;
                                    state_q <= icm_pkg::hs_stop;
                                end
                            end
                        end
                    endcase
                end
                icm_pkg::hs_stop: if (tick) begin
                    // data low, clock high, data rises
                    qph_q <= qph_q + 2'h1;
                    case (qph_q)
                        2'h0: sda_oen_q <= 1'b0;
                        2'h1: scl_oen_q <= 1'b1;
                        2'h2: sda_oen_q <= 1'b1;
                        default: begin
                            busy_q <= 1'b0;
                            state_q <= icm_pkg::hs_idle;
                        end
                    endcase
                end
                default: state_q <= icm_pkg::hs_idle;
            endcase
        end
    end

    // read bytes are pushed once the acknowledge bit is out
    icm_fifo #(.W(8), .D(DEPTH)) u_rx_fifo (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .in_valid_i(push_q),
        .in_data_i(rx_q[8:1]),
        .in_ready_o(fifo_rdy),
        .out_valid_o(rdata_valid_o),
        .out_data_o(rdata_o),
        .out_ready_i(rdata_ready_i)
    );
endmodule : icm_host_end
`default_nettype wire

// ### hdl/icm_defs.svh
// timing counts, address map and field constants of the config memory port
`ifndef ICM_DEFS_SVH
`define ICM_DEFS_SVH
`define ICM_CLK_NS 10
`define ICM_SCL_NS 10000
`define ICM_QTR_CYC (`ICM_SCL_NS / (4 * `ICM_CLK_NS))
`define ICM_CFG_LAST 8'h9F
`define ICM_GP0_BASE 8'hA0
`define ICM_GP1_BASE 8'hC0
`define ICM_LOCK_REG 8'h9F
`define ICM_LOCK_RST 2'h0
`define ICM_PAGE_BYTES 16
`define ICM_MEM_BYTES 256
`define ICM_FIFO_DEPTH 4
`endif

// ### hdl/icm_pkg.sv
// types and address decoding shared by both ends of the config memory port
`default_nettype none
`include "icm_defs.svh"
package icm_pkg;
    typedef enum logic [1:0] {rgn_cfg, rgn_gp0, rgn_gp1} icm_region_type;
    typedef enum logic [2:0] {ds_idle, ds_addr, ds_ptr, ds_wr,
        ds_rd} icm_dev_state_type;
    typedef enum logic [2:0] {hs_idle, hs_start, hs_load, hs_bits,
        hs_stop} icm_host_state_type;
    typedef enum logic [2:0] {st_addr_w, st_ptr, st_wdat, st_addr_r,
        st_rdat} icm_host_step_type;

    function automatic icm_region_type icm_region(input logic [7:0] a);
        if (a <= `ICM_CFG_LAST) begin
            return rgn_cfg;
        end else if (a < `ICM_GP1_BASE) begin
            return rgn_gp0;
        end
        return rgn_gp1;
    endfunction : icm_region

    function automatic logic icm_locked(input logic [7:0] a,
                                        input logic [1:0] lock);
        return (icm_region(a) == rgn_gp0 && lock[0]) ||
               (icm_region(a) == rgn_gp1 && lock[1]);
    endfunction : icm_locked
endpackage : icm_pkg
`default_nettype wire

// ### hdl/icm_link_if.sv
// two-wire link joining the host end and the device end
`timescale 1ns/1ns
`default_nettype none
interface icm_link_if;
    logic scl_o, scl_oe_n, h_sda_o, h_sda_oe_n, d_sda_o, d_sda_oe_n;
    logic scl, sda;
    // open drain: a released driver lets the line float high
    assign scl = scl_oe_n | scl_o;
    assign sda = (h_sda_oe_n | h_sda_o) & (d_sda_oe_n | d_sda_o);
    modport host (output scl_o, scl_oe_n, h_sda_o, h_sda_oe_n,
                  input scl, sda);
    modport dev (output d_sda_o, d_sda_oe_n, input scl, sda);
endinterface : icm_link_if
`default_nettype wire

// ### hdl/icm_fifo.sv
// small valid/ready fifo with registered flags
`timescale 1ns/1ns
`default_nettype none
`include "icm_defs.svh"
module icm_fifo #(
    parameter int W = 8,
    parameter int D = `ICM_FIFO_DEPTH
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_q, rp_q;
    logic [CW-1:0] cnt_q, cnt_d;
    logic in_ready_q, out_valid_q, push, pop;

    assign push = in_valid_i & in_ready_q;
    assign pop = out_valid_q & out_ready_i;
    assign cnt_d = cnt_q + CW'(push) - CW'(pop);
    assign in_ready_o = in_ready_q;
    assign out_valid_o = out_valid_q;
    assign out_data_o = mem[rp_q];

    function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
        return (p == AW'(D - 1)) ? '0 : p + 1'b1;
    endfunction : nxt

    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem[wp_q] <= in_data_i;
        end
    end

    // flags come from the next count, so full and empty never lag
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            in_ready_q <= 1'b0;
            out_valid_q <= 1'b0;
        end else begin
            if (push) wp_q <= nxt(wp_q);
            if (pop) rp_q <= nxt(rp_q);
            cnt_q <= cnt_d;
            in_ready_q <= (cnt_d != CW'(D));
            out_valid_q <= (cnt_d != '0);
        end
    end
endmodule : icm_fifo
`default_nettype wire

// ### hdl/icm_dev_end.sv
// device end: two-wire slave reaching config registers and lockable memory
// Notes on behaviour
// - sample data at clock rise, change at fall
// - msb-first bytes, each followed by acknowledge
// - data changes during clock high mean start/stop
// - one programmable 7-bit address, last bit read/write
// - one address reaches every internal space
// - write: address, ack, pointer, ack, data
// - up to sixteen bytes per page write
// - programming begins only on the closing stop
// - host loads pointer by dummy write, repeated start
// - reads stream from pointer while host acknowledges
// - host ends read with no-ack then stop
// - pointers 00 to 9F are configuration space
// - memory block zero A0-BF, block one C0-FF
// - each memory block has its own lock bit
`timescale 1ns/1ns
`default_nettype none
`include "icm_defs.svh"
module icm_dev_end #(
    parameter int PAGE = `ICM_PAGE_BYTES
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    icm_link_if.dev link,
    input wire logic [6:0] slave_addr_i,
    output logic busy_o,
    output logic [1:0] lock_o
);
    localparam int PW = $clog2(PAGE);

    icm_pkg::icm_dev_state_type state_q;
    logic scl_q, sda_q, scl_rise, scl_fall, start, stop;
    logic [3:0] bitcnt_q;
    logic [7:0] rx_q, tx_q, ptr_q, rd_byte, cur;
    logic match_q, rw_q, mack_q, sda_oen_q, drv_lo_q, hit;
    logic [7:0] mem [`ICM_MEM_BYTES];
    logic [7:0] pbuf [PAGE];
    logic [PAGE-1:0] pvld_q;
    logic [7-PW:0] page_q;
    logic [PW-1:0] cidx_q;
    logic busy_q, wr_take, mem_we;
    logic [1:0] lock_q;

    // ------------------------------------------------------------
    // line events
    // ------------------------------------------------------------
    // inputs arrive synchronous; one stored copy gives the edges
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            drv_lo_q <= 1'b0;
        end else begin
            scl_q <= link.scl;
            sda_q <= link.sda;
            drv_lo_q <= 1'b0;
        end
    end

    assign scl_rise = link.scl & ~scl_q;
    assign scl_fall = ~link.scl & scl_q;
    assign start = link.scl & scl_q & sda_q & ~link.sda;
    assign stop = link.scl & scl_q & ~sda_q & link.sda;
    assign hit = (rx_q[7:1] == slave_addr_i) && !busy_q;
    // one pointer, lock register read back from flops
    assign rd_byte = (ptr_q == `ICM_LOCK_REG) ? {6'h0, lock_q} : mem[ptr_q];

    assign link.d_sda_o = drv_lo_q;
    assign link.d_sda_oe_n = sda_oen_q;
    assign busy_o = busy_q;
    assign lock_o = lock_q;

    // ------------------------------------------------------------
    // protocol engine
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= icm_pkg::ds_idle;
            bitcnt_q <= 4'h0;
            rx_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= 8'h00;
            match_q <= 1'b0;
            rw_q <= 1'b0;
            mack_q <= 1'b0;
            sda_oen_q <= 1'b1;
        end else if (start) begin
            state_q <= icm_pkg::ds_addr;
            // start's own clock fall wraps this to zero, not bit one
            bitcnt_q <= 4'hF;
            sda_oen_q <= 1'b1;
        end else if (stop) begin
            state_q <= icm_pkg::ds_idle;
            sda_oen_q <= 1'b1;
        end else if (state_q != icm_pkg::ds_idle) begin
            if (scl_rise) begin
                if (bitcnt_q < 4'h8) begin
                    rx_q <= {rx_q[6:0], link.sda};
                end else begin
                    mack_q <= ~link.sda;
                end
            end
            if (scl_fall) begin
                if (bitcnt_q == 4'h7) begin
                    bitcnt_q <= 4'h8;
                    case (state_q)
                        icm_pkg::ds_addr: begin
                            match_q <= hit;
                            rw_q <= rx_q[0];
                            sda_oen_q <= ~hit;
                        end
                        icm_pkg::ds_ptr: begin
                            ptr_q <= rx_q;
                            sda_oen_q <= 1'b0;
                        end
                        icm_pkg::ds_wr: begin
                            ptr_q <= {ptr_q[7:PW], ptr_q[PW-1:0] + 1'b1};
                            sda_oen_q <= 1'b0;
                        end
                        default: sda_oen_q <= 1'b1;
                    endcase
                end else if (bitcnt_q == 4'h8) begin
                    bitcnt_q <= 4'h0;
                    sda_oen_q <= 1'b1;
                    case (state_q)
                        icm_pkg::ds_addr: begin
                            if (!match_q) begin
                                state_q <= icm_pkg::ds_idle;
                            end else if (rw_q) begin
                                state_q <= icm_pkg::ds_rd;
                                tx_q <= {rd_byte[6:0], 1'b0};
                                sda_oen_q <= rd_byte[7];
                                ptr_q <= ptr_q + 8'h01;
                            end else begin
                                state_q <= icm_pkg::ds_ptr;
                            end
                        end
                        icm_pkg::ds_ptr: state_q <= icm_pkg::ds_wr;
                        icm_pkg::ds_rd: begin
                            if (mack_q) begin
                                tx_q <= {rd_byte[6:0], 1'b0};
                                sda_oen_q <= rd_byte[7];
                                ptr_q <= ptr_q + 8'h01;
                            end else begin
                                state_q <= icm_pkg::ds_idle;
                            end
                        end
                        default: state_q <= state_q;
                    endcase
                end else begin
                    bitcnt_q <= bitcnt_q + 4'h1;
                    if (state_q == icm_pkg::ds_rd) begin
                        sda_oen_q <= tx_q[7];
                        tx_q <= {tx_q[6:0], 1'b0};
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // page buffer and commit
    // ------------------------------------------------------------
    // data bytes collect in the page buffer
    assign wr_take = scl_fall && bitcnt_q == 4'h7 &&
                     state_q == icm_pkg::ds_wr;
    assign cur = {page_q, cidx_q};
    // skip locked blocks, lock reg in flops
    assign mem_we = busy_q && pvld_q[cidx_q] && cur != `ICM_LOCK_REG &&
                    !icm_pkg::icm_locked(cur, lock_q);

    always_ff @(posedge clk_sys_i) begin
        if (wr_take) begin
            pbuf[ptr_q[PW-1:0]] <= rx_q;
        end
        if (mem_we) begin
            mem[cur] <= pbuf[cidx_q];
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pvld_q <= '0;
            page_q <= '0;
            cidx_q <= '0;
            busy_q <= 1'b0;
            lock_q <= `ICM_LOCK_RST;
        end else if (busy_q) begin
            if (pvld_q[cidx_q] && cur == `ICM_LOCK_REG) begin
                lock_q <= pbuf[cidx_q][1:0];
            end
            cidx_q <= cidx_q + 1'b1;
            if (cidx_q == PW'(PAGE - 1)) begin
                busy_q <= 1'b0;
                pvld_q <= '0;
            end
        end else if (stop && pvld_q != '0) begin
            busy_q <= 1'b1;
            cidx_q <= '0;
        end else if (start) begin
            // data left without a stop is dropped
            pvld_q <= '0;
        end else if (wr_take) begin
            pvld_q[ptr_q[PW-1:0]] <= 1'b1;
            page_q <= ptr_q[7:PW];
        end
    end
endmodule : icm_dev_end
`default_nettype wire

// ### verif/icm_link_sva.sv
// checker watching the two-wire link between the two ends
`timescale 1ns/1ns
`default_nettype none
module icm_link_sva (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic scl_o,
    input wire logic h_sda_o,
    input wire logic h_sda_oe_n,
    input wire logic d_sda_o,
    input wire logic d_sda_oe_n,
    input wire logic scl,
    input wire logic sda
);
    // ----
    // start/stop decode and clock count
    // ----
    logic scl_q, sda_q;
    logic [8:0] cnt_q;
    wire st = scl && scl_q && sda_q && !sda;
    wire sp = scl && scl_q && !sda_q && sda;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            scl_q <= 1'h1;
            sda_q <= 1'h1;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
        end
    end
    // counts start or stop rise too, hence the remainder of one
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q <= 9'h000;
        end else if (st || sp) begin
            cnt_q <= 9'h000;
        end else if (scl && !scl_q) begin
            cnt_q <= cnt_q + 9'h001;
        end
    end
    open_drain_a: assert property (!scl_o && !h_sda_o && !d_sda_o)
        else $error("line driven high");
    dev_edge_a: assert property ($changed(d_sda_oe_n) |-> !scl)
        else $error("device data moved with clock high");
    scl_high_a: assert property ($rose(scl) |-> scl [*8])
        else $error("clock high too short");
    host_edge_a: assert property ($changed(h_sda_oe_n) && scl && scl_q
        |-> st || sp) else $error("host data moved with clock high");
    start_clk_a: assert property (st |-> ##[1:16] !scl)
        else $error("no clock after start");
    stop_hold_a: assert property (sp |-> scl [*8])
        else $error("clock moved after stop");
    one_drv_a: assert property (!d_sda_oe_n && scl |-> h_sda_oe_n)
        else $error("both ends drive data");
    byte_frame_a: assert property (st || sp |-> cnt_q == 9'h000
        || cnt_q % 9 == 1) else $error("frame not whole bytes");
    start_c: cover property (st);
    stop_c: cover property (sp);
    ack_c: cover property (!d_sda_oe_n && scl);
endmodule : icm_link_sva
`default_nettype wire

// ### verif/i2c_config_memory_slave_test.sv
// self-checking bench joining the host end and the device end
`timescale 1ns/1ns
`default_nettype none
module i2c_config_memory_slave_test;
    logic clk_sys_i = 1'h0, nrst_i = 1'h0;
    logic cv, crd, wv, rr, hrdy, wrdy, rv, nack, dbusy, hbusy;
    logic [6:0] ca;
    logic [7:0] cp, wd, rd;
    logic [4:0] cl;
    logic [1:0] lock;
    logic [7:0] wq[$], rq[$];
    int num_errors, samples_checked, cyc, bcnt;
    icm_link_if link();
    icm_host_end #(.QTR(8)) u_icm_host_end (.clk_sys_i, .nrst_i,
        .link(link.host), .cmd_valid_i(cv), .cmd_read_i(crd),
        .cmd_addr_i(ca), .cmd_ptr_i(cp), .cmd_len_i(cl), .cmd_ready_o(hrdy),
        .wdata_valid_i(wv), .wdata_i(wd), .wdata_ready_o(wrdy),
        .rdata_valid_o(rv), .rdata_o(rd), .rdata_ready_i(rr), .busy_o(hbusy),
        .nack_o(nack));
    icm_dev_end u_icm_dev_end (.clk_sys_i, .nrst_i, .link(link.dev),
        .slave_addr_i(7'h7F), .busy_o(dbusy), .lock_o(lock));
    icm_link_sva u_icm_link_sva (.clk_sys_i, .nrst_i, .scl_o(link.scl_o),
        .h_sda_o(link.h_sda_o), .h_sda_oe_n(link.h_sda_oe_n),
        .d_sda_o(link.d_sda_o), .d_sda_oe_n(link.d_sda_oe_n),
        .scl(link.scl), .sda(link.sda));
    initial forever #5 clk_sys_i = ~clk_sys_i;
    // ceiling far above the seventy-odd bytes moved
    always @(posedge clk_sys_i) begin
        cyc++;
        bcnt += dbusy;
        if (cyc == 90000) begin
            num_errors++;
            final_report();
        end
    end
    task chk(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // n of zero: no data moved, used where a refusal is expected
    task xfer(input logic r, input logic [6:0] a, input logic [7:0] p,
              input int n, input int stall);
        @(negedge clk_sys_i);
        {cv, crd, ca, cp, cl} = {1'h1, r, a, p, 5'(n + (n == 0))};
        do @(posedge clk_sys_i); while (!hrdy);
        @(negedge clk_sys_i);
        cv = 1'h0;
        rq = {};
        repeat (stall) @(negedge clk_sys_i);
        rr = r && n > 0;
        for (int i = 0; i < n; i++) begin
            if (r) begin
                do @(posedge clk_sys_i); while (!rv);
                rq.push_back(rd);
            end else begin
                if (i > 0) @(negedge clk_sys_i);
                {wv, wd} = {1'h1, wq[i]};
                do @(posedge clk_sys_i); while (!wrdy);
            end
        end
        @(negedge clk_sys_i);
        {wv, rr} = 2'h0;
        do @(posedge clk_sys_i); while (!hrdy);
        repeat (20) @(posedge clk_sys_i);
    endtask : xfer
    task t_nak;
        xfer(1'h0, 7'h00, 8'h00, 0, 0);
        chk({6'h00, hbusy, nack}, 8'h01);
        wq = {8'h11};
        xfer(1'h0, 7'h7F, 8'h10, 1, 0);
        chk({7'h00, nack}, 8'h00);
    endtask : t_nak
    task t_cfg;
        wq = {8'h3C, 8'hC3};
        xfer(1'h0, 7'h7F, 8'h00, 2, 0);
        xfer(1'h1, 7'h7F, 8'h00, 2, 0);
        chk(rq[0], 8'h3C);
        chk(rq[1], 8'hC3);
    endtask : t_cfg
    task t_wrap;
        wq = {};
        for (int i = 1; i < 18; i++) wq.push_back(8'(i));
        bcnt = 0;
        xfer(1'h0, 7'h7F, 8'hA0, 17, 0);
        chk(8'(bcnt), 8'h10);
        // long stall fills the read buffer and stops the clock
        xfer(1'h1, 7'h7F, 8'hA0, 16, 2600);
        for (int i = 0; i < 16; i++) chk(rq[i], 8'(i ? i + 1 : 17));
    endtask : t_wrap
    task t_lock;
        wq = {8'h5A};
        xfer(1'h0, 7'h7F, 8'hC0, 1, 0);
        wq = {8'h02};
        xfer(1'h0, 7'h7F, 8'h9F, 1, 0);
        chk({6'h00, lock}, 8'h02);
        wq = {8'hA5};
        xfer(1'h0, 7'h7F, 8'hC0, 1, 0);
        xfer(1'h0, 7'h7F, 8'hA0, 1, 0);
        xfer(1'h1, 7'h7F, 8'h9F, 2, 0);
        chk(rq[0], 8'h02);
        chk(rq[1], 8'hA5);
        xfer(1'h1, 7'h7F, 8'hC0, 1, 0);
        chk(rq[0], 8'h5A);
    endtask : t_lock
    task final_report;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report
    initial begin
        {cv, crd, ca, cp, cl, wv, wd, rr} = '0;
        repeat (12) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        nrst_i = 1'h1;
        repeat (2) @(posedge clk_sys_i);
        t_nak;
        t_cfg;
        t_wrap;
        t_lock;
        final_report();
    end
endmodule : i2c_config_memory_slave_test
`default_nettype wire
